// ---- core/epc_pkg.sv ----
package epc_pkg;
  // Data path width of count, reload and samples
  localparam int DATA_W = 32;
  // Register bus address width
  localparam int ADDR_W = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_RELOAD = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam logic [7:0] ADDR_PERIOD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // Control register width and field positions
  localparam int CTRL_W = 10;
  localparam int CTRL_POS_BIT = 0;
  localparam int CTRL_GATE_FALL_BIT = 2;
  localparam int CTRL_SRC_FALL_BIT = 3;
  localparam int CTRL_DEC_LO = 4;
  localparam int CTRL_DEC_HI = 5;
  localparam int CTRL_PH_B_BIT = 6;
  localparam int CTRL_PH_A_BIT = 7;
  localparam int CTRL_RLD_EN_BIT = 8;
  localparam int CTRL_BUF_BIT = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

  // Command register bits
  localparam int CMD_ARM_BIT = 0;
  localparam int CMD_DISARM_BIT = 1;

  // Status register width and bit positions
  localparam int STAT_W = 3;
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  // Reset value of the reload register
  localparam logic [DATA_W-1:0] RELOAD_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COUNT_ONE = 32'h0000_0001;

  // Synchroniser input bit positions
  localparam int SYNC_W = 5;
  localparam int IN_SRC = 0;
  localparam int IN_GATE = 1;
  localparam int IN_A = 2;
  localparam int IN_B = 3;
  localparam int IN_Z = 4;

  // Encoder decoding styles
  localparam logic [1:0] DEC_X1 = 2'h0;
  localparam logic [1:0] DEC_X2 = 2'h1;
  localparam logic [1:0] DEC_X4 = 2'h2;
  localparam logic [1:0] DEC_TWO_PULSE = 2'h3;

  // Period measurement states
  typedef enum logic [1:0] {
    PER_IDLE,
    PER_WAIT,
    PER_COUNT,
    PER_DONE
  } epc_per_state_t;
endpackage

// ---- core/epc_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for all asynchronous pins
module epc_sync (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Raw pins and clean levels
  input wire logic [epc_pkg::SYNC_W-1:0] async_in,
  output logic [epc_pkg::SYNC_W-1:0] sync_out
);

  ////////////////////////////////////////////////////////////////////////////
  // One pair of flops per pin; the first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < epc_pkg::SYNC_W; gi = gi + 1) begin : g_bit
      logic meta_r;
      logic clean_r;
      // Both stages reset low; a pin high at release appears two edges later
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_r <= 1'b0;
          clean_r <= 1'b0;
        end else begin
          meta_r <= async_in[gi];
          clean_r <= meta_r;
        end
      end
      assign sync_out[gi] = clean_r;
    end
  endgenerate

endmodule
`default_nettype wire

// ---- core/epc_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Armed period mode measures one gate period
// - Gate active edge selectable rising or falling
// - Count source edges between active gate edges
// - Position count changes only after arming
// - On-demand read or sample-clocked buffered readout
// - X1 counts on A rise up, fall down
// - X2 counts on both A edges
// - X4 counts on every A and B edge
// - Index high in reload phase loads value
// - Reload phase is any of four AB states
// - Count step first, reload afterwards
// - Reload within one timebase period, then continue
// - Two-pulse: A rise up, B rise down
// - Buffered mode streams count at sample edges
// - Samples never clear the cumulative count
// - Sample clock on gate, edge selectable
module epc_counter (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [epc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [epc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [epc_pkg::DATA_W-1:0] rdata_out,
  // Counter pins
  input wire logic source_in,
  input wire logic gate_in,
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  input wire logic enc_z_in,
  // Sample stream toward host memory
  output logic sample_valid_out,
  output logic [epc_pkg::DATA_W-1:0] sample_data_out,
  // Status levels
  output logic armed_out,
  output logic period_done_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  // Synchronised pin levels and their previous values
  logic [epc_pkg::SYNC_W-1:0] pin_s;
  logic [epc_pkg::SYNC_W-1:0] pin_q_r;

  // Software registers
  logic [epc_pkg::CTRL_W-1:0] ctrl_r;
  logic [epc_pkg::DATA_W-1:0] reload_r;
  logic [epc_pkg::DATA_W-1:0] period_r;
  logic [epc_pkg::DATA_W-1:0] period_nxt;
  logic done_r;
  logic done_nxt;
  logic armed_r;
  logic armed_nxt;
  logic [epc_pkg::DATA_W-1:0] rdata_r;
  logic [epc_pkg::DATA_W-1:0] rdata_nxt;

  // Core count and period state
  logic [epc_pkg::DATA_W-1:0] count_r;
  logic [epc_pkg::DATA_W-1:0] count_nxt;
  epc_pkg::epc_per_state_t per_state_r;
  epc_pkg::epc_per_state_t per_state_nxt;

  // Sample stream registers
  logic sample_valid_r;
  logic [epc_pkg::DATA_W-1:0] sample_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  // All five pins cross into the counter timebase here
  epc_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({enc_z_in, enc_b_in, enc_a_in, gate_in, source_in}),
    .sync_out(pin_s)
  );

  // Previous levels for edge detection on clean signals only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q_r <= '0;
    end else begin
      pin_q_r <= pin_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control field decode
  wire pos_mode = ctrl_r[epc_pkg::CTRL_POS_BIT];
  wire gate_fall = ctrl_r[epc_pkg::CTRL_GATE_FALL_BIT];
  wire src_fall = ctrl_r[epc_pkg::CTRL_SRC_FALL_BIT];
  wire [1:0] dec_mode = ctrl_r[epc_pkg::CTRL_DEC_HI:epc_pkg::CTRL_DEC_LO];
  wire [1:0] rld_phase = {ctrl_r[epc_pkg::CTRL_PH_A_BIT], ctrl_r[epc_pkg::CTRL_PH_B_BIT]};
  wire rld_en = ctrl_r[epc_pkg::CTRL_RLD_EN_BIT];
  wire buffered = ctrl_r[epc_pkg::CTRL_BUF_BIT];

  // Register strobes
  wire wr_ctrl = wr_in && (addr_in == epc_pkg::ADDR_CTRL);
  wire wr_cmd = wr_in && (addr_in == epc_pkg::ADDR_CMD);
  wire wr_reload = wr_in && (addr_in == epc_pkg::ADDR_RELOAD);
  wire wr_status = wr_in && (addr_in == epc_pkg::ADDR_STATUS);
  wire arm_cmd = wr_cmd && wdata_in[epc_pkg::CMD_ARM_BIT];
  wire disarm_cmd = wr_cmd && wdata_in[epc_pkg::CMD_DISARM_BIT] && !arm_cmd;
  wire done_clr = wr_status && wdata_in[epc_pkg::STAT_DONE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection
  // Clean current and previous levels
  wire src_c = pin_s[epc_pkg::IN_SRC];
  wire src_p = pin_q_r[epc_pkg::IN_SRC];
  wire gate_c = pin_s[epc_pkg::IN_GATE];
  wire gate_p = pin_q_r[epc_pkg::IN_GATE];
  wire a_c = pin_s[epc_pkg::IN_A];
  wire a_p = pin_q_r[epc_pkg::IN_A];
  wire b_c = pin_s[epc_pkg::IN_B];
  wire b_p = pin_q_r[epc_pkg::IN_B];
  wire z_c = pin_s[epc_pkg::IN_Z];

  // Active source edge, rising or falling by choice
  wire src_edge = src_fall ? (src_p && !src_c) : (!src_p && src_c);
  // Active gate edge, used as period gate or sample clock
  wire gate_edge = gate_fall ? (gate_p && !gate_c) : (!gate_p && gate_c);

  // Raw encoder edges
  wire a_rise = !a_p && a_c;
  wire a_fall = a_p && !a_c;
  wire b_rise = !b_p && b_c;
  wire a_chg = a_p ^ a_c;
  wire b_chg = b_p ^ b_c;
  // High when A leads B for this transition
  wire dir_up = a_c ^ b_p;
  // A jump of both phases at once is illegal and ignored
  wire one_chg = a_chg ^ b_chg;

  ////////////////////////////////////////////////////////////////////////////
  // Quadrature and two-pulse step decode
  logic step_up;
  logic step_dn;

  // Per decoding style, one step up or down at most
  always_comb begin
    case (dec_mode)
      epc_pkg::DEC_X1: begin
        // Up on A rise when A leads, down on A fall when B leads
        step_up = a_rise && !b_chg && dir_up;
        step_dn = a_fall && !b_chg && !dir_up;
      end
      epc_pkg::DEC_X2: begin
        // Both A edges count, direction from phase order
        step_up = a_chg && !b_chg && dir_up;
        step_dn = a_chg && !b_chg && !dir_up;
      end
      epc_pkg::DEC_X4: begin
        // Every single-phase edge counts
        step_up = one_chg && dir_up;
        step_dn = one_chg && !dir_up;
      end
      epc_pkg::DEC_TWO_PULSE: begin
        // A rise counts up, B rise down; both at once cancel
        step_up = a_rise && !b_rise;
        step_dn = b_rise && !a_rise;
      end
      default: begin
        step_up = 1'b0;
        step_dn = 1'b0;
      end
    endcase
  end

  // Position counting live only while armed
  wire pos_live = armed_r && pos_mode;
  // Index high in the programmed AB phase
  wire in_phase = ({a_c, b_c} == rld_phase);
  // Step wins; reload waits one clock, which is one timebase period
  wire reload_hit = pos_live && rld_en && z_c && in_phase && !step_up && !step_dn;

  // Sample capture on the gate in buffered position mode
  wire sample_hit = pos_live && buffered && gate_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Count and period state machine
  // Next count, period state, result, arm and done
  always_comb begin
    count_nxt = count_r;
    per_state_nxt = per_state_r;
    period_nxt = period_r;
    armed_nxt = armed_r;
    done_nxt = done_r;
    if (arm_cmd) begin
      // Arming starts from zero so samples are cumulative from here
      count_nxt = '0;
      armed_nxt = 1'b1;
      done_nxt = 1'b0;
      per_state_nxt = pos_mode ? epc_pkg::PER_IDLE : epc_pkg::PER_WAIT;
    end else if (disarm_cmd) begin
      // Count is kept for reading; state goes idle
      armed_nxt = 1'b0;
      per_state_nxt = epc_pkg::PER_IDLE;
    end else if (pos_live) begin
      if (step_up) begin
        count_nxt = count_r + epc_pkg::COUNT_ONE;
      end else if (step_dn) begin
        count_nxt = count_r - epc_pkg::COUNT_ONE;
      end else if (reload_hit) begin
        count_nxt = reload_r;
      end
    end else if (armed_r) begin
      case (per_state_r)
        epc_pkg::PER_WAIT: begin
          // First active gate edge opens the period
          if (gate_edge) begin
            count_nxt = '0;
            per_state_nxt = epc_pkg::PER_COUNT;
          end
        end
        epc_pkg::PER_COUNT: begin
          if (gate_edge) begin
            // Second active gate edge closes it; a coincident source edge is not counted
            period_nxt = count_r;
            per_state_nxt = epc_pkg::PER_DONE;
            armed_nxt = 1'b0;
            done_nxt = 1'b1;
          end else if (src_edge) begin
            count_nxt = count_r + epc_pkg::COUNT_ONE;
          end
        end
        epc_pkg::PER_IDLE: begin
          per_state_nxt = epc_pkg::PER_WAIT;
        end
        epc_pkg::PER_DONE: begin
          per_state_nxt = epc_pkg::PER_DONE;
        end
        default: begin
          per_state_nxt = epc_pkg::PER_IDLE;
        end
      endcase
    end
    // Completion wins over a clear in the same cycle; arm has already cleared it
    if (done_clr && !(done_nxt && !done_r)) begin
      done_nxt = 1'b0;
    end
  end

  // Core state flops
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
      per_state_r <= epc_pkg::PER_IDLE;
      period_r <= '0;
      armed_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      per_state_r <= per_state_nxt;
      period_r <= period_nxt;
      armed_r <= armed_nxt;
      done_r <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample stream
  // Captured value is the count before this cycle's step; the count is untouched
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sample_valid_r <= 1'b0;
      sample_data_r <= '0;
    end else begin
      sample_valid_r <= sample_hit;
      if (sample_hit) begin
        sample_data_r <= count_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software register writes
  // Control and reload value; changes take effect next clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= epc_pkg::CTRL_RESET;
      reload_r <= epc_pkg::RELOAD_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_in[epc_pkg::CTRL_W-1:0];
      end
      if (wr_reload) begin
        reload_r <= wdata_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Status word: armed, done, period in progress
  wire per_busy = armed_r && !pos_mode;
  wire [epc_pkg::STAT_W-1:0] status_w = {per_busy, done_r, armed_r};

  // On-demand read path; unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    case (addr_in)
      epc_pkg::ADDR_CTRL: rdata_nxt = {{(epc_pkg::DATA_W-epc_pkg::CTRL_W){1'b0}}, ctrl_r};
      epc_pkg::ADDR_RELOAD: rdata_nxt = reload_r;
      epc_pkg::ADDR_COUNT: rdata_nxt = count_r;
      epc_pkg::ADDR_PERIOD: rdata_nxt = period_r;
      epc_pkg::ADDR_STATUS: rdata_nxt = {{(epc_pkg::DATA_W-epc_pkg::STAT_W){1'b0}}, status_w};
      default: rdata_nxt = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rd_in ? rdata_nxt : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign rdata_out = rdata_r;
  assign sample_valid_out = sample_valid_r;
  assign sample_data_out = sample_data_r;
  assign armed_out = armed_r;
  assign period_done_out = done_r;

endmodule
`default_nettype wire

// ---- test/epc_counter_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// Port-level checks of the counter channel
module epc_counter_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // Gate pin, stream and status
  input wire logic gate_in,
  input wire logic sample_valid_out,
  input wire logic [31:0] sample_data_out,
  input wire logic armed_out,
  input wire logic period_done_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Arm command, status read and unmapped read decode
  wire logic arm_wr = wr_in && addr_in == epc_pkg::ADDR_CMD && wdata_in[epc_pkg::CMD_ARM_BIT];
  wire logic st_rd = rd_in && addr_in == epc_pkg::ADDR_STATUS;
  wire logic hole_rd = rd_in && addr_in > epc_pkg::ADDR_STATUS;
  ////////////////////////////////////////////////////////////////
  // Read data stand in the answer cycle only
  AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data not zero outside the answer cycle");
  AST_RD_HOLE: assert property (hole_rd |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  // Status word mirrors the status levels of the read cycle
  AST_STATUS: assert property (st_rd |=> rdata_out[1:0] == {$past(period_done_out), $past(armed_out)})
    else $error("status bits differ from status levels");
  AST_ARM: assert property (arm_wr |=> armed_out)
    else $error("arm command not taken");
  // A finished period ends the armed state in the same cycle
  AST_DONE_DISARM: assert property ($rose(period_done_out) |-> !armed_out && $past(armed_out))
    else $error("period done without leaving armed");
  // Gate edges are at least two cycles apart, so a sample is one pulse
  AST_PULSE: assert property (sample_valid_out |=> !sample_valid_out)
    else $error("sample valid longer than one cycle");
  AST_KEEP: assert property (!sample_valid_out |-> $stable(sample_data_out))
    else $error("sample data moved without a sample");
  // Latency through the synchroniser allows a three-cycle window
  AST_GATE: assert property (sample_valid_out |->
    $past(gate_in, 3) != $past(gate_in, 4) || $past(gate_in, 4) != $past(gate_in, 5) ||
    $past(gate_in, 5) != $past(gate_in, 6))
    else $error("sample without a gate edge");
  // Main scenarios reached
  COV_DONE: cover property ($rose(period_done_out));
  COV_SAMPLE: cover property (sample_valid_out);
  COV_STATUS: cover property (st_rd ##1 rdata_out[1]);
endmodule
bind epc_counter epc_counter_asserts epc_counter_asserts_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .gate_in(gate_in),
  .sample_valid_out(sample_valid_out), .sample_data_out(sample_data_out), .armed_out(armed_out),
  .period_done_out(period_done_out));
`default_nettype wire

// ---- test/epc_enc_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Encoder and periodic source standing at the counter pins
module epc_enc_model (
  // Clock that times every pin change
  input wire logic clk_in,
  // Encoder phases and index
  output logic a_out,
  output logic b_out,
  output logic z_out,
  // Source and gate lines
  output logic src_out,
  output logic gate_out
);
  // Quadrature state 0..3 walks {A,B} as 00,10,11,01
  int s = 0;
  initial begin
    {a_out, b_out, z_out, src_out, gate_out} = 5'h00;
  end
  ////////////////////////////////////////////////////////////////
  // Wait a number of clock edges
  task automatic hold(input int h);
    repeat (h) @(posedge clk_in);
  endtask
  // One quadrature step; only one phase moves, so no step is ambiguous
  task automatic go(input logic f, input int zp, input int h);
    @(posedge clk_in);
    s = f ? (s + 1) % 4 : (s + 3) % 4;
    a_out <= s == 1 || s == 2;
    b_out <= s >= 2;
    z_out <= s == zp;
    hold(h);
  endtask
  // Two-pulse encoder: a rising pulse on A, or on B for the other way
  task automatic pulse(input logic ch, input int h);
    @(posedge clk_in);
    a_out <= ~ch;
    b_out <= ch;
    hold(h);
    a_out <= 1'b0;
    b_out <= 1'b0;
    s = 0;
    hold(h);
  endtask
  // Inactive level first so that the edge after it is the active one
  task automatic edge_g(input logic act, input int h);
    @(posedge clk_in);
    gate_out <= ~act;
    hold(h);
    gate_out <= act;
    hold(h);
  endtask
  // One gate period holding n whole source pulses; source idles low
  task automatic per(input int n, input logic act, input int h);
    edge_g(act, h);
    repeat (n) begin // Source always faster than the gate
      src_out <= 1'b1;
      hold(h);
      src_out <= 1'b0;
      hold(h);
    end
    edge_g(act, h);
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench of the counter channel
module testbench;
  // Clock, reset and register port
  logic clk_in;
  logic rst_n_in;
  logic [7:0] addr_in;
  logic [31:0] wdata_in;
  logic wr_in;
  logic rd_in;
  wire logic [31:0] rdata_out;
  // Pins, stream and status
  wire logic src, gate, enc_a, enc_b, enc_z, sample_valid_out, armed_out, period_done_out;
  wire logic [31:0] sample_data_out;
  // Bench state and captured samples
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] rng = 32'haa18;
  logic [31:0] got, e, rld;
  logic f;
  int n;
  logic [31:0] q[$];
  epc_counter epc_counter_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .source_in(src), .gate_in(gate), .enc_a_in(enc_a),
    .enc_b_in(enc_b), .enc_z_in(enc_z), .sample_valid_out(sample_valid_out), .sample_data_out(sample_data_out),
    .armed_out(armed_out), .period_done_out(period_done_out));
  epc_enc_model epc_enc_model_inst (.clk_in(clk_in), .a_out(enc_a), .b_out(enc_b), .z_out(enc_z),
    .src_out(src), .gate_out(gate));
  ////////////////////////////////////////////////////////////////
  // Xorshift draw from the fixed seed
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // Expected count change of one move from state s in style md
  function automatic logic [31:0] dv(input int md, input int s, input logic f);
    if (md == epc_pkg::DEC_TWO_PULSE) return f ? -1 : 1;
    if (md == epc_pkg::DEC_X4) return f ? 1 : -1;
    if (md == epc_pkg::DEC_X2) return (s % 2 == (f ? 0 : 1)) ? (f ? 1 : -1) : 0;
    return (f && s == 0) ? 1 : (!f && s == 1) ? -1 : 0;
  endfunction
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= ad;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Register read; data taken at the edge after the strobe edge
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= ad;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    d = rdata_out;
  endtask
  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    total_checks++;
    if (gv !== ev) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, gv, ev);
    end
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] ev);
    rd(ad, got);
    chk(got, ev);
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Watchdog far beyond the thousand or so cycles of the sequence
  initial begin
    #(100 * 20000);
    num_errors++;
    stop_test();
  end
  // Stream capture; there is no back-pressure, so every pulse is kept
  always @(posedge clk_in) if (sample_valid_out === 1'b1) q.push_back(sample_data_out);
  initial begin
    {rst_n_in, wr_in, rd_in, addr_in, wdata_in} = '0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Reset values, read-only count and an unmapped place
    rc(epc_pkg::ADDR_CTRL, 32'h0);
    rc(epc_pkg::ADDR_STATUS, 32'h0);
    rld = xs();
    wr(epc_pkg::ADDR_COUNT, rld);
    wr(8'h18, rld);
    rc(epc_pkg::ADDR_COUNT, 32'h0);
    rc(8'h18, 32'h0);
    wr(epc_pkg::ADDR_RELOAD, rld);
    rc(epc_pkg::ADDR_RELOAD, rld);
    // Period under each gate edge and source edge choice
    for (int i = 0; i < 4; i++) begin
      n = 1 + xs() % 8;
      wr(epc_pkg::ADDR_CTRL, (i % 2) << epc_pkg::CTRL_GATE_FALL_BIT | (i / 2) << epc_pkg::CTRL_SRC_FALL_BIT);
      wr(epc_pkg::ADDR_CMD, 32'h1);
      epc_enc_model_inst.per(n, i % 2 == 0, 3 + xs() % 3);
      rc(epc_pkg::ADDR_PERIOD, n);
      rc(epc_pkg::ADDR_STATUS, 32'h2);
    end
    // Done is cleared by writing one to it
    wr(epc_pkg::ADDR_STATUS, 32'h2);
    rc(epc_pkg::ADDR_STATUS, 32'h0);
    // Each decoding style: still while disarmed, then a random walk
    for (int md = 0; md < 4; md++) begin
      wr(epc_pkg::ADDR_CMD, 32'h2);
      wr(epc_pkg::ADDR_CTRL, 1 | md << epc_pkg::CTRL_DEC_LO);
      rd(epc_pkg::ADDR_COUNT, got);
      // A full cycle and two B pulses would move the count in every style
      repeat (4) epc_enc_model_inst.go(1'b1, -1, 3);
      repeat (2) epc_enc_model_inst.pulse(1'b1, 3);
      rc(epc_pkg::ADDR_COUNT, got);
      wr(epc_pkg::ADDR_CMD, 32'h1);
      e = 0;
      repeat (12) begin
        f = 1'(xs() % 2);
        e += dv(md, epc_enc_model_inst.s, f);
        if (md == 3) epc_enc_model_inst.pulse(f, 3 + xs() % 3);
        else epc_enc_model_inst.go(f, -1, 3 + xs() % 3);
      end
      rc(epc_pkg::ADDR_COUNT, e);
    end
    // Index reload in each phase; the step lands first, the reload after it
    for (int p = 0; p < 4; p++) begin
      rld = xs();
      wr(epc_pkg::ADDR_RELOAD, rld);
      wr(epc_pkg::ADDR_CTRL, 1 | epc_pkg::DEC_X4 << epc_pkg::CTRL_DEC_LO | 1 << epc_pkg::CTRL_RLD_EN_BIT |
        (p == 1 || p == 2) << epc_pkg::CTRL_PH_A_BIT | (p >= 2) << epc_pkg::CTRL_PH_B_BIT);
      wr(epc_pkg::ADDR_CMD, 32'h1);
      e = 0;
      repeat (6) begin
        epc_enc_model_inst.go(1'b1, p, 3 + xs() % 3);
        e = epc_enc_model_inst.s == p ? rld : e + 1;
      end
      rc(epc_pkg::ADDR_COUNT, e);
    end
    // Buffered samples on either gate edge, cumulative since arming
    for (int g = 0; g < 2; g++) begin
      wr(epc_pkg::ADDR_CTRL, 1 | epc_pkg::DEC_X4 << epc_pkg::CTRL_DEC_LO | g << epc_pkg::CTRL_GATE_FALL_BIT |
        1 << epc_pkg::CTRL_BUF_BIT);
      wr(epc_pkg::ADDR_CMD, 32'h1);
      e = 0;
      q.delete();
      repeat (3) begin
        repeat (1 + xs() % 4) begin
          f = 1'(xs() % 2);
          e += dv(epc_pkg::DEC_X4, 0, f);
          epc_enc_model_inst.go(f, -1, 3);
        end
        epc_enc_model_inst.edge_g(g == 0, 3 + xs() % 3);
        epc_enc_model_inst.hold(3);
        if (q.size() == 1) chk(q.pop_front(), e);
        else chk(q.size(), 1);
      end
    end
    stop_test();
  end
endmodule
`default_nettype wire
